//--- rtl/bsfx_params.svh
// Bit positions, reset values and cycle figures for the bit/shift/flag unit
`ifndef BSFX_PARAMS_SVH
`define BSFX_PARAMS_SVH
// ----------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------
`define BSFX_FLAG_C 3'd0
`define BSFX_FLAG_Z 3'd1
`define BSFX_FLAG_N 3'd2
`define BSFX_FLAG_V 3'd3
`define BSFX_FLAG_S 3'd4
`define BSFX_FLAG_H 3'd5
`define BSFX_FLAG_T 3'd6
`define BSFX_FLAG_I 3'd7
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define BSFX_FLAGS_RST 8'h00
`define BSFX_ALU_CYCLES 3'd1
`define BSFX_SRAM_EXTRA 3'd1
`endif

//--- rtl/bsfx_pkg.sv
// Types shared by the bit/shift/flag unit
package bsfx_pkg;
    typedef enum logic [3:0] {
        BSFX_NOP,
        BSFX_ROTATE_LEFT_CARRY,
        BSFX_ROTATE_RIGHT_CARRY,
        BSFX_ARITH_SHIFT_RIGHT,
        BSFX_NIBBLE_SWAP,
        BSFX_FLAG_SET,
        BSFX_FLAG_CLEAR,
        BSFX_IO_BIT_SET,
        BSFX_IO_BIT_CLEAR,
        BSFX_REG_BIT_TO_FLAG,
        BSFX_FLAG_TO_REG_BIT,
        BSFX_MEM_ACCESS
    } bsfx_opc_t;

    // One issued operation with its operands
    typedef struct packed {
        bsfx_opc_t opc;
        logic [7:0] reg_val;
        logic [2:0] bit_sel;
        logic [4:0] io_addr;
        logic [7:0] io_val;
        logic [2:0] base_cyc;
        logic to_sram;
        logic to_ext;
    } bsfx_op_t;

    // Register file write-back
    typedef struct packed {
        logic we;
        logic [7:0] data;
    } bsfx_wb_t;

    // Low I/O space write
    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } bsfx_io_t;
endpackage : bsfx_pkg

//--- rtl/bsfx_mem_timer.sv
// Cycle counter for data-memory accesses
`timescale 1ns/1ps
`default_nettype none
`include "bsfx_params.svh"
module bsfx_mem_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [2:0] total,
    input wire logic to_ext,
    input wire logic ext_ack,
    output logic busy,
    output logic fin,
    output logic done
);
    import bsfx_pkg::*;
    logic [2:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt, done_r, done_nxt, ext_r, ext_nxt;

    // Last counted cycle; external accesses also wait for the far side
    assign fin = busy_r && (cnt_r == 3'd0) && (!ext_r || ext_ack);
    assign busy = busy_r;
    assign done = done_r;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        ext_nxt = ext_r;
        done_nxt = 1'b0;
        if (start) begin
            ext_nxt = to_ext;
            if (total <= `BSFX_ALU_CYCLES && !to_ext) begin
                done_nxt = 1'b1;
            end else begin
                busy_nxt = 1'b1;
                cnt_nxt = (total >= 3'd2) ? total - 3'd2 : 3'd0;
            end
        end else if (busy_r) begin
            if (cnt_r != 3'd0) begin
                cnt_nxt = cnt_r - 3'd1;
            end else if (fin) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= 3'd0;
            busy_r <= 1'b0;
            ext_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            ext_r <= ext_nxt;
            done_r <= done_nxt;
        end
    end
endmodule : bsfx_mem_timer
`default_nettype wire

//--- rtl/bsfx_exec.sv
// Bit, shift and status-flag execution unit of the core
`timescale 1ns/1ps
`default_nettype none
`include "bsfx_params.svh"
module bsfx_exec (
    input wire logic clk,
    input wire logic srst,
    input wire logic op_valid,
    input wire bsfx_pkg::bsfx_op_t op,
    input wire logic ext_ack,
    output logic op_ready,
    output bsfx_pkg::bsfx_wb_t wb,
    output bsfx_pkg::bsfx_io_t io_wr,
    output logic [7:0] status_flags,
    output logic done,
    output logic mem_done
);
    import bsfx_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Flags for the shift family: N from result, V = N^C, S = N^V
    function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] r,
                                               input logic c);
        logic [7:0] o;
        o = f;
        o[`BSFX_FLAG_C] = c;
        o[`BSFX_FLAG_Z] = (r == 8'h00);
        o[`BSFX_FLAG_N] = r[7];
        o[`BSFX_FLAG_V] = r[7] ^ c;
        o[`BSFX_FLAG_S] = r[7] ^ (r[7] ^ c);
        return o;
    endfunction : shift_flags

    // Total cycles of a memory access
    function automatic logic [2:0] mem_total(input logic [2:0] base, input logic sram);
        return sram ? base + `BSFX_SRAM_EXTRA : base;
    endfunction : mem_total

    logic accept, mem_start, mem_busy, mem_fin, mem_done_w;
    logic [7:0] flags_r, flags_nxt;
    bsfx_wb_t wb_r, wb_nxt;
    bsfx_io_t io_r, io_nxt;
    logic done_r, done_nxt, ready_r, ready_nxt;
    logic [2:0] tot;

    assign accept = op_valid && ready_r;
    assign mem_start = accept && (op.opc == BSFX_MEM_ACCESS);
    assign tot = mem_total(op.base_cyc, op.to_sram);

    // ----------------------------------------------------------------
    // Memory access timing
    // ----------------------------------------------------------------
    // External accesses are held until the far side acknowledges
    bsfx_mem_timer u_timer (
        .clk(clk),
        .srst(srst),
        .start(mem_start),
        .total(tot),
        .to_ext(op.to_ext),
        .ext_ack(ext_ack),
        .busy(mem_busy),
        .fin(mem_fin),
        .done(mem_done_w)
    );

    // ----------------------------------------------------------------
    // Execute: results, flags and I/O writes
    // ----------------------------------------------------------------
    always_comb begin
        flags_nxt = flags_r;
        wb_nxt = '0;
        io_nxt = '0;
        done_nxt = 1'b0;
        if (accept && op.opc != BSFX_MEM_ACCESS) begin
            done_nxt = 1'b1;
            unique case (op.opc)
                BSFX_NOP: begin
                end
                BSFX_ROTATE_LEFT_CARRY: begin
                    wb_nxt = '{we: 1'b1, data: {op.reg_val[6:0], flags_r[`BSFX_FLAG_C]}};
                    flags_nxt = shift_flags(flags_r, wb_nxt.data, op.reg_val[7]);
                    flags_nxt[`BSFX_FLAG_H] = op.reg_val[3];
                end
                BSFX_ROTATE_RIGHT_CARRY: begin
                    wb_nxt = '{we: 1'b1, data: {flags_r[`BSFX_FLAG_C], op.reg_val[7:1]}};
                    flags_nxt = shift_flags(flags_r, wb_nxt.data, op.reg_val[0]);
                end
                BSFX_ARITH_SHIFT_RIGHT: begin
                    wb_nxt = '{we: 1'b1, data: {op.reg_val[7], op.reg_val[7:1]}};
                    flags_nxt = shift_flags(flags_r, wb_nxt.data, op.reg_val[0]);
                end
                BSFX_NIBBLE_SWAP: begin
                    wb_nxt = '{we: 1'b1, data: {op.reg_val[3:0], op.reg_val[7:4]}};
                end
                BSFX_FLAG_SET: begin
                    flags_nxt[op.bit_sel] = 1'b1;
                end
                BSFX_FLAG_CLEAR: begin
                    flags_nxt[op.bit_sel] = 1'b0;
                end
                BSFX_IO_BIT_SET: begin
                    io_nxt = '{we: 1'b1, addr: op.io_addr, data: op.io_val};
                    io_nxt.data[op.bit_sel] = 1'b1;
                end
                BSFX_IO_BIT_CLEAR: begin
                    io_nxt = '{we: 1'b1, addr: op.io_addr, data: op.io_val};
                    io_nxt.data[op.bit_sel] = 1'b0;
                end
                BSFX_REG_BIT_TO_FLAG: begin
                    flags_nxt[`BSFX_FLAG_T] = op.reg_val[op.bit_sel];
                end
                BSFX_FLAG_TO_REG_BIT: begin
                    wb_nxt = '{we: 1'b1, data: op.reg_val};
                    wb_nxt.data[op.bit_sel] = flags_r[`BSFX_FLAG_T];
                end
                default: begin
                    done_nxt = 1'b0; // Undefined codes are dropped
                end
            endcase
        end
    end

    // Ready drops while a multi-cycle memory access runs
    always_comb begin
        if (mem_start) begin
            ready_nxt = (tot <= `BSFX_ALU_CYCLES) && !op.to_ext;
        end else if (mem_busy) begin
            ready_nxt = mem_fin;
        end else begin
            ready_nxt = 1'b1;
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_r <= `BSFX_FLAGS_RST;
            wb_r <= '0;
            io_r <= '0;
            done_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            wb_r <= wb_nxt;
            io_r <= io_nxt;
            done_r <= done_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign wb = wb_r;
    assign io_wr = io_r;
    assign status_flags = flags_r;
    assign done = done_r;
    assign op_ready = ready_r;
    assign mem_done = mem_done_w;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_take(bsfx_opc_t o);
        op_valid && op_ready && op.opc == o;
    endsequence

    a_rotate_left: assert property (@(posedge clk) disable iff (srst)
        s_take(BSFX_ROTATE_LEFT_CARRY) |=> wb.we && wb.data == {$past(op.reg_val[6:0]), $past(flags_r[0])}
            && status_flags[0] == $past(op.reg_val[7]) && status_flags[5] == $past(op.reg_val[3]))
        else $error("rotate left result wrong");
    a_rotate_right: assert property (@(posedge clk) disable iff (srst)
        s_take(BSFX_ROTATE_RIGHT_CARRY) |=> wb.data[7] == $past(flags_r[0])
            && status_flags[0] == $past(op.reg_val[0]) && status_flags[1] == (wb.data == 8'h00))
        else $error("rotate right result wrong");
    a_io_set: assert property (@(posedge clk) disable iff (srst)
        s_take(BSFX_IO_BIT_SET) |=> io_wr.we && io_wr.data[$past(op.bit_sel)] && $stable(status_flags))
        else $error("I/O bit set wrong");
    a_io_clear: assert property (@(posedge clk) disable iff (srst)
        s_take(BSFX_IO_BIT_CLEAR) |=> io_wr.we && !io_wr.data[$past(op.bit_sel)] && $stable(status_flags))
        else $error("I/O bit clear wrong");
    a_bit_store: assert property (@(posedge clk) disable iff (srst)
        s_take(BSFX_REG_BIT_TO_FLAG) |=> status_flags[6] == $past(op.reg_val[op.bit_sel])
            && status_flags[5:0] == $past(flags_r[5:0]) && !wb.we)
        else $error("bit store to T wrong");
    a_bit_load: assert property (@(posedge clk) disable iff (srst)
        s_take(BSFX_FLAG_TO_REG_BIT) |=> wb.data[$past(op.bit_sel)] == $past(flags_r[6]) && $stable(status_flags))
        else $error("bit load from T wrong");
    a_flag_write: assert property (@(posedge clk) disable iff (srst)
        (s_take(BSFX_FLAG_SET) or s_take(BSFX_FLAG_CLEAR)) |=> done
            && status_flags[$past(op.bit_sel)] == ($past(op.opc) == BSFX_FLAG_SET)
            && (status_flags ^ $past(flags_r)) == (($past(flags_r[op.bit_sel]) == status_flags[$past(op.bit_sel)])
                ? 8'h00 : (8'h01 << $past(op.bit_sel))))
        else $error("flag set or clear wrong");
    a_sram_extra: assert property (@(posedge clk) disable iff (srst)
        (s_take(BSFX_MEM_ACCESS) && op.to_sram && !op.to_ext && op.base_cyc == 3'd2) |=> !mem_done [*2] ##1 mem_done)
        else $error("SRAM access not one cycle longer");
    a_ext_wait: assert property (@(posedge clk) disable iff (srst)
        (mem_busy && u_timer.ext_r && !ext_ack) |=> !mem_done)
        else $error("external access ended without acknowledge");
    a_shift_sign: assert property (@(posedge clk) disable iff (srst)
        s_take(BSFX_ARITH_SHIFT_RIGHT) |=> wb.data[7:6] == {2{$past(op.reg_val[7])}}
            && status_flags[0] == $past(op.reg_val[0]))
        else $error("arithmetic shift wrong");
    a_swap_nib: assert property (@(posedge clk) disable iff (srst)
        s_take(BSFX_NIBBLE_SWAP) |=> wb.data == {$past(op.reg_val[3:0]), $past(op.reg_val[7:4])}
            && $stable(status_flags))
        else $error("nibble swap wrong");
endmodule : bsfx_exec
`default_nettype wire

//--- dv/tb_bit_shift_flag_execution.sv
// Self-checking bench for the bit/shift/flag execution unit
`timescale 1ns/1ps
`default_nettype none
`include "bsfx_params.svh"
module tb_bit_shift_flag_execution;
    import bsfx_pkg::*;
    // ----------------------------------------------------------------
    // Signals and reference state
    // ----------------------------------------------------------------
    logic clk;
    logic srst;
    logic op_valid;
    bsfx_op_t op;
    logic ext_ack;
    logic op_ready;
    bsfx_wb_t wb;
    bsfx_io_t io_wr;
    logic [7:0] status_flags;
    logic done;
    logic mem_done;
    logic [7:0] fl; // Expected flags
    int fails = 0;
    int compares = 0;

    bsfx_exec DUT (.clk(clk), .srst(srst), .op_valid(op_valid), .op(op), .ext_ack(ext_ack),
        .op_ready(op_ready), .wb(wb), .io_wr(io_wr), .status_flags(status_flags), .done(done),
        .mem_done(mem_done));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // Reference model; flags follow the shift results, S = N^V
    function automatic void model(input bsfx_op_t o, inout logic [7:0] f, output logic [7:0] res,
                                  output logic rwe, output logic iowe, output logic [7:0] iod);
        logic [7:0] r;
        logic sh;
        r = o.reg_val;
        res = r;
        iod = o.io_val;
        rwe = 1'b0;
        iowe = 1'b0;
        sh = 1'b0;
        case (o.opc)
            BSFX_ROTATE_LEFT_CARRY: begin
                res = {r[6:0], f[`BSFX_FLAG_C]};
                f[`BSFX_FLAG_H] = r[3];
                f[`BSFX_FLAG_C] = r[7];
                sh = 1'b1;
            end
            BSFX_ROTATE_RIGHT_CARRY: begin
                res = {f[`BSFX_FLAG_C], r[7:1]};
                f[`BSFX_FLAG_C] = r[0];
                sh = 1'b1;
            end
            BSFX_ARITH_SHIFT_RIGHT: begin
                res = {r[7], r[7:1]};
                f[`BSFX_FLAG_C] = r[0];
                sh = 1'b1;
            end
            BSFX_NIBBLE_SWAP: begin
                res = {r[3:0], r[7:4]};
                rwe = 1'b1;
            end
            BSFX_FLAG_SET: f[o.bit_sel] = 1'b1;
            BSFX_FLAG_CLEAR: f[o.bit_sel] = 1'b0;
            BSFX_IO_BIT_SET: begin
                iod[o.bit_sel] = 1'b1;
                iowe = 1'b1;
            end
            BSFX_IO_BIT_CLEAR: begin
                iod[o.bit_sel] = 1'b0;
                iowe = 1'b1;
            end
            BSFX_REG_BIT_TO_FLAG: f[`BSFX_FLAG_T] = r[o.bit_sel];
            BSFX_FLAG_TO_REG_BIT: begin
                res[o.bit_sel] = f[`BSFX_FLAG_T];
                rwe = 1'b1;
            end
            default: ; // Undefined codes leave everything alone
        endcase
        if (sh) begin
            rwe = 1'b1;
            f[`BSFX_FLAG_Z] = (res == 8'h00);
            f[`BSFX_FLAG_N] = res[7];
            f[`BSFX_FLAG_V] = res[7] ^ f[`BSFX_FLAG_C];
            f[`BSFX_FLAG_S] = f[`BSFX_FLAG_N] ^ f[`BSFX_FLAG_V];
        end
    endfunction : model

    // One non-memory op; op_valid stays up so calls run back to back
    task automatic issue(input bsfx_op_t o);
        logic [7:0] res;
        logic [7:0] iod;
        logic rwe;
        logic iowe;
        int n;
        op_valid = 1'b1;
        op = o;
        n = 0;
        while (op_ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        model(o, fl, res, rwe, iowe, iod);
        @(posedge clk);
        #1;
        check(16'(wb.we), 16'(rwe));
        if (rwe) check(16'(wb.data), 16'(res));
        check(16'(io_wr.we), 16'(iowe));
        if (iowe) check({3'h0, io_wr.addr, io_wr.data}, {3'h0, o.io_addr, iod});
        check(16'(status_flags), 16'(fl));
        check(16'(done), 16'(o.opc inside {[BSFX_NOP:BSFX_FLAG_TO_REG_BIT]}));
    endtask : issue

    // Memory access; counts edges from acceptance to mem_done
    task automatic mem_op(input logic [2:0] base, input logic sram, input logic ext);
        bsfx_op_t o;
        int k;
        int tot;
        o = '0;
        o.opc = BSFX_MEM_ACCESS;
        o.base_cyc = base;
        o.to_sram = sram;
        o.to_ext = ext;
        tot = base + sram;
        ext_ack = ext ? 1'b0 : 1'($urandom); // Ack must not matter internally
        op_valid = 1'b1;
        op = o;
        @(posedge clk);
        #1;
        op_valid = 1'b0;
        k = 1;
        if (tot > 1 || ext) check(16'(op_ready), 16'h0000);
        while (mem_done !== 1'b1 && k < 14) begin
            if (ext && k == tot + 3) ext_ack = 1'b1;
            @(posedge clk);
            #1;
            k++;
        end
        if (ext) check(16'(k > tot + 3 && k <= tot + 5), 16'h0001);
        else check(16'(k), 16'(tot));
        check(16'(op_ready), 16'h0001);
    endtask : mem_op

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        #200000;
        fails++;
        final_report();
    end

    // Reset, flag codes, boundaries, random ops, memory timing, reset again
    initial begin : main
        bsfx_op_t o;
        srst = 1'b1;
        op_valid = 1'b0;
        op = '0;
        ext_ack = 1'b0;
        fl = `BSFX_FLAGS_RST;
        void'($urandom(2));
        repeat (8) @(posedge clk);
        #1;
        srst = 1'b0;
        check(16'(status_flags), 16'(fl));
        check(16'(op_ready), 16'h0000);
        @(posedge clk);
        #1;
        check(16'(op_ready), 16'h0001);
        o = '0;
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 8; s++) begin
                o.opc = p ? BSFX_FLAG_CLEAR : BSFX_FLAG_SET;
                o.bit_sel = 3'(s);
                issue(o);
            end
        end
        // Edge values: zero result from a rotate, sign kept by the shift
        o.opc = BSFX_ROTATE_LEFT_CARRY;
        o.reg_val = 8'h80;
        issue(o);
        o.opc = BSFX_ROTATE_RIGHT_CARRY;
        o.reg_val = 8'h01;
        issue(o);
        o.opc = BSFX_ARITH_SHIFT_RIGHT;
        o.reg_val = 8'h81;
        issue(o);
        for (int i = 0; i < 300; i++) begin
            o.opc = bsfx_opc_t'(4'($urandom % 11));
            o.reg_val = 8'($urandom);
            o.bit_sel = 3'($urandom);
            o.io_addr = 5'($urandom);
            o.io_val = 8'($urandom);
            issue(o);
        end
        o.opc = bsfx_opc_t'(4'hF);
        issue(o);
        for (int b = 1; b < 4; b++) begin
            mem_op(3'(b), 1'b0, 1'b0);
            mem_op(3'(b), 1'b1, 1'b0);
        end
        mem_op(3'h2, 1'b1, 1'b1);
        mem_op(3'h1, 1'b0, 1'b1);
        o.opc = BSFX_NIBBLE_SWAP;
        o.reg_val = 8'hA5;
        issue(o);
        // Second reset in mid-run clears the flags
        op_valid = 1'b0;
        srst = 1'b1;
        @(posedge clk);
        #1;
        srst = 1'b0;
        fl = `BSFX_FLAGS_RST;
        check(16'(status_flags), 16'(fl));
        check(16'(op_ready), 16'h0000);
        check(16'(done), 16'h0000);
        @(posedge clk);
        #1;
        check(16'(op_ready), 16'h0001);
        o.opc = BSFX_REG_BIT_TO_FLAG;
        o.bit_sel = 3'h7;
        issue(o);
        final_report();
    end
endmodule : tb_bit_shift_flag_execution
`default_nettype wire
